/* rtl/ips_pkg.sv */
// shared constants and types for the sensor serial port and power control
package ips_pkg;

  //////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_KHZ  = 10_000;                 // system clock rate
  localparam int INIT_US  = 500;                    // power-on init time
  localparam int INIT_CYC = INIT_US * CLK_KHZ / 1000;
  localparam int INIT_W   = 16;
  localparam int OSC_KHZ  = 720;                    // nominal oscillator
  localparam int OSC_W    = 5;
  localparam int OSC_DIV  = CLK_KHZ / OSC_KHZ;      // clk cycles per tick
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV - 1);
  localparam int HQ_QTR   = 4;                      // host scl quarter

  //////////////////////////////////////////////////////////////////////////
  // serial byte framing
  localparam logic [3:0] BIT_LAST = 4'h7;           // last data bit
  localparam logic [3:0] BIT_ACK  = 4'h8;           // ninth clock

  //////////////////////////////////////////////////////////////////////////
  // device register map
  localparam logic [7:0] REG_ENABLE  = 8'h80;
  localparam logic [7:0] REG_ID      = 8'h92;
  localparam logic [7:0] REG_ALS_LO  = 8'h95;
  localparam logic [7:0] REG_ALS_HI  = 8'h96;
  localparam logic [7:0] REG_STATUS4 = 8'h9F;
  localparam logic [7:0] REG_CFG0    = 8'hA1;
  localparam logic [7:0] REG_AGC_LO  = 8'hAC;
  localparam logic [7:0] REG_AGC_HI  = 8'hAD;
  localparam logic [7:0] REG_CONTROL = 8'hB1;
  localparam logic [7:0] ENABLE_RST  = 8'h00;
  localparam logic [7:0] CFG0_RST    = 8'h08;
  localparam int EN_PON       = 0;                  // power_on_bit
  localparam int EN_AEN       = 1;                  // light_measure_enable
  localparam int EN_FDEN      = 6;                  // flicker enable
  localparam int CFG0_SAI     = 6;                  // sleep_after_interrupt
  localparam int ST4_SAI      = 0;                  // forced_sleep_active_flag
  localparam int CTRL_CLR_SAI = 3;                  // clears the flag

  //////////////////////////////////////////////////////////////////////////
  // host wishbone map and command fields
  localparam logic [3:0] HB_CMD  = 4'h0;
  localparam logic [3:0] HB_TX   = 4'h4;
  localparam logic [3:0] HB_RX   = 4'h8;
  localparam logic [3:0] HB_STAT = 4'hC;
  localparam int CMD_KIND = 0;
  localparam int CMD_TWO  = 2;
  localparam int CMD_DEV  = 8;
  localparam int CMD_REG  = 16;

  //////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {PS_INIT = 2'b00, PS_SLEEP = 2'b01,
                            PS_IDLE = 2'b11, PS_ACTIVE = 2'b10} ips_pwr_t;
  typedef enum logic [2:0] {SL_IDLE = 3'h0, SL_RECV = 3'h1, SL_ACK = 3'h3,
                            SL_SEND = 3'h2, SL_RACK = 3'h6} ips_slv_t;
  typedef enum logic [1:0] {K_WRITE = 2'b00, K_READ = 2'b01,
                            K_READNP = 2'b11} ips_kind_t;
  typedef enum logic [2:0] {IT_START, IT_AW, IT_AR, IT_REG, IT_TX0,
                            IT_TX1, IT_RX, IT_STOP} ips_item_t;

endpackage

/* rtl/ips_if.sv */
// two-wire bus carrier joining the host and the sensor port
`timescale 1ns/1ps
interface ips_if;
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic scl;
  logic sda;

  // wired-and with pull-ups: any enabled low driver pulls the line down
  assign scl = ~(hostSclOe & ~hostSclOut);
  assign sda = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));

  modport host   (output hostSclOut, hostSclOe, hostSdaOut, hostSdaOe,
                  input scl, sda);
  modport device (output devSdaOut, devSdaOe, input scl, sda);
endinterface

/* rtl/ips_device.sv */
// sensor end: two-wire register slave and power state sequencing
// Function
// - no acknowledge and no access during init
// - host waits for init, ignores outputs; ips_host starts at once, so a read during init gets a nack
// - init ends in sleep, oscillator stopped
// - bus traffic served while staying asleep
// - power-on bit moves sleep to idle
// - function enable active, none enabled idle
// - light and flicker run concurrently, independent
// - sleep-after-interrupt sends machine to sleep
// - forced sleep keeps registers and power-on
// - clearing active flag ends forced sleep
// - seven-bit slave address, standard and fast
// - eight-bit pointer increments per data byte
// - pointer kept across stop for reads
// - low byte read latches high byte
// - host accesses sixteen-bit fields low first
// - host prefers burst transfers
// - write: start, address, register, data, stop
// - ack or nack on ninth clock
// - read uses repeated start then data
// - master acks all but last byte
// - oscillator nominally 720 kHz
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module ips_device
  import ips_pkg::*;
#(
  parameter logic [6:0] SLV_ADDR    = 7'h29,
  parameter logic [7:0] DEV_ID      = 8'hA5,   // arbitrary value
  parameter int         INIT_CYCLES = INIT_CYC
)(
  input  logic          clk,
  input  logic          resetn,
  ips_if.device         bus,
  input  logic [15:0]   alsData,
  input  logic          intEvent,
  output ips_pwr_t      pwrState,
  output logic          initDone,
  output logic          oscRun,
  output logic          alsRun,
  output logic          fdRun,
  output logic          forcedSleep,
  output logic [15:0]   agcSamples
);

  localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);

  typedef struct packed {
    logic [1:0]        sclS;
    logic [1:0]        sdaS;
    logic              sclD;
    logic              sdaD;
    ips_slv_t          slv;
    logic [3:0]        bitCnt;
    logic [7:0]        shift;
    logic              firstByte;
    logic              ptrLoaded;
    logic              rw;
    logic              nackSeen;
    logic              sdaOe;
    logic [7:0]        ptr;
    logic [7:0]        enable;
    logic [7:0]        cfg0;
    logic [7:0]        alsHold;
    logic [7:0]        agcLo;
    logic [15:0]       agc;
    logic              forced;
    ips_pwr_t          pwr;
    logic [INIT_W-1:0] initCnt;
    logic [OSC_W-1:0]  oscCnt;
    logic              initDone;
    logic              oscRun;
    logic              alsRun;
    logic              fdRun;
  } ips_dev_st_t;

  localparam ips_dev_st_t RST = '{sclS: 2'b11, sdaS: 2'b11, sclD: 1'b1,
                                  sdaD: 1'b1, slv: SL_IDLE, pwr: PS_INIT,
                                  enable: ENABLE_RST, cfg0: CFG0_RST,
                                  default: '0};

  ips_dev_st_t r;
  ips_dev_st_t n;
  logic        sclRise;
  logic        sclFall;
  logic        startCond;
  logic        stopCond;
  logic        oscTick;
  logic        setSai;
  logic [7:0]  rdByte;
  logic        wrEn;
  logic        clrSai;
  logic        loadRd;

  ////////////////////////////////////////////////////////////////////////////
  // bus conditions seen on the synchronised lines only
  assign sclRise   = r.sclS[1] & ~r.sclD;
  assign sclFall   = ~r.sclS[1] & r.sclD;
  assign startCond = r.sclS[1] & r.sclD & r.sdaD & ~r.sdaS[1];
  assign stopCond  = r.sclS[1] & r.sclD & ~r.sdaD & r.sdaS[1];
  // oscillator tick, only while the oscillator runs
  assign oscTick   = r.oscRun && (r.oscCnt == OSC_LAST);
  // interrupt only counts while measuring or idle
  assign setSai    = intEvent & r.cfg0[CFG0_SAI] &
                     ((r.pwr == PS_IDLE) || (r.pwr == PS_ACTIVE));

  ////////////////////////////////////////////////////////////////////////////
  // read data for the byte under the pointer
  always_comb
  begin
    if (r.ptr == REG_ENABLE)
      rdByte = r.enable;
    else if (r.ptr == REG_ID)
      rdByte = DEV_ID;
    else if (r.ptr == REG_ALS_LO)
      rdByte = alsData[7:0];
    else if (r.ptr == REG_ALS_HI)
      rdByte = r.alsHold;
    else if (r.ptr == REG_STATUS4)
      rdByte = 8'(r.forced) << ST4_SAI;
    else if (r.ptr == REG_CFG0)
      rdByte = r.cfg0;
    else if (r.ptr == REG_AGC_LO)
      rdByte = r.agc[7:0];
    else if (r.ptr == REG_AGC_HI)
      rdByte = r.agc[15:8];
    else
      rdByte = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole block
  always_comb
  begin
    n      = r;
    wrEn   = 1'b0;
    clrSai = 1'b0;
    loadRd = 1'b0;
    // two flops per line; runs on clk so sleep never blocks the bus
    n.sclS = {r.sclS[0], bus.scl};
    n.sdaS = {r.sdaS[0], bus.sda};
    n.sclD = r.sclS[1];
    n.sdaD = r.sdaS[1];

    // serial slave, independent of power state once init is done
    case (r.slv)
      SL_RECV:
      begin
        if (sclRise)
        begin
          n.shift  = {r.shift[6:0], r.sdaS[1]};
          n.bitCnt = r.bitCnt + 4'h1;
        end
        else if (sclFall && r.bitCnt == BIT_ACK)
        begin
          n.slv   = SL_ACK;
          n.sdaOe = 1'b1;
          if (r.firstByte)
          begin
            n.firstByte = 1'b0;
            n.rw        = r.shift[0];
            // wrong address or still initialising: leave line high
            if (r.shift[7:1] != SLV_ADDR || !r.initDone)
            begin
              n.slv   = SL_IDLE;
              n.sdaOe = 1'b0;
            end
          end
          else if (!r.ptrLoaded)
          begin
            n.ptr       = r.shift;
            n.ptrLoaded = 1'b1;
          end
          else
          begin
            wrEn  = 1'b1;
            n.ptr = r.ptr + 8'h01;
          end
        end
      end
      SL_ACK:
      begin
        if (sclFall)
        begin
          n.sdaOe  = 1'b0;
          n.bitCnt = 4'h0;
          n.slv    = SL_RECV;
          loadRd   = r.rw;
        end
      end
      SL_SEND:
      begin
        if (sclFall)
        begin
          if (r.bitCnt == BIT_LAST)
          begin
            n.sdaOe = 1'b0;
            n.slv   = SL_RACK;
          end
          else
          begin
            n.shift  = {r.shift[6:0], 1'b0};
            n.bitCnt = r.bitCnt + 4'h1;
            n.sdaOe  = ~r.shift[6];
          end
        end
      end
      SL_RACK:
      begin
        if (sclRise)
          n.nackSeen = r.sdaS[1];
        else if (sclFall)
        begin
          // a not-acknowledge ends our sending
          if (r.nackSeen)
            n.slv = SL_IDLE;
          else
            loadRd = 1'b1;
        end
      end
      default: n.slv = SL_IDLE;
    endcase

    // load next read byte; low half of a pair latches the high half
    if (loadRd)
    begin
      n.shift  = rdByte;
      n.sdaOe  = ~rdByte[7];
      n.ptr    = r.ptr + 8'h01;
      n.bitCnt = 4'h0;
      n.slv    = SL_SEND;
      if (r.ptr == REG_ALS_LO)
        n.alsHold = alsData[15:8];
    end

    // start or repeated start restarts framing, pointer stays
    if (startCond)
    begin
      n.slv       = SL_RECV;
      n.bitCnt    = 4'h0;
      n.firstByte = 1'b1;
      n.ptrLoaded = 1'b0;
      n.sdaOe     = 1'b0;
    end
    else if (stopCond)
    begin
      n.slv   = SL_IDLE;
      n.sdaOe = 1'b0;
    end

    // register writes
    if (wrEn)
    begin
      if (r.ptr == REG_ENABLE)
        n.enable = r.shift;
      else if (r.ptr == REG_CFG0)
        n.cfg0 = r.shift;
      else if (r.ptr == REG_AGC_LO)
        n.agcLo = r.shift;
      else if (r.ptr == REG_AGC_HI)
        n.agc = {r.shift, r.agcLo};
      else if (r.ptr == REG_CONTROL)
        clrSai = r.shift[CTRL_CLR_SAI];
    end

    // flag: a new interrupt beats a clear in the same cycle
    if (setSai)
      n.forced = 1'b1;
    else if (clrSai)
      n.forced = 1'b0;

    // oscillator divider, stopped outside idle and active
    n.oscCnt = (r.oscRun && !oscTick) ? r.oscCnt + 5'h01 : '0;

    // power states; forced sleep leaves every register alone
    case (r.pwr)
      PS_INIT:
      begin
        if (r.initCnt == INIT_LAST)
          n.pwr = PS_SLEEP;
        else
          n.initCnt = r.initCnt + 16'h0001;
      end
      PS_SLEEP:
      begin
        if (r.enable[EN_PON] && !r.forced)
          n.pwr = PS_IDLE;
      end
      PS_IDLE:
      begin
        if (!r.enable[EN_PON] || setSai)
          n.pwr = PS_SLEEP;
        else if (oscTick && (r.enable[EN_AEN] || r.enable[EN_FDEN]))
          n.pwr = PS_ACTIVE;
      end
      PS_ACTIVE:
      begin
        if (!r.enable[EN_PON] || setSai)
          n.pwr = PS_SLEEP;
        else if (oscTick && !r.enable[EN_AEN] && !r.enable[EN_FDEN])
          n.pwr = PS_IDLE;
      end
      default: n.pwr = PS_INIT;
    endcase

    // registered outputs follow the next state
    n.initDone = (n.pwr != PS_INIT);
    n.oscRun   = (n.pwr == PS_IDLE) || (n.pwr == PS_ACTIVE);
    n.alsRun   = (n.pwr == PS_ACTIVE) && n.enable[EN_AEN];
    n.fdRun    = (n.pwr == PS_ACTIVE) && n.enable[EN_FDEN];
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      r <= RST;
    else
      r <= n;
  end

  assign bus.devSdaOut = 1'b0;      // open drain: only ever pulls low
  assign bus.devSdaOe  = r.sdaOe;
  assign pwrState      = r.pwr;
  assign initDone      = r.initDone;
  assign oscRun        = r.oscRun;
  assign alsRun        = r.alsRun;
  assign fdRun         = r.fdRun;
  assign forcedSleep   = r.forced;
  assign agcSamples    = r.agc;

endmodule

/* rtl/ips_host.sv */
// host end: wishbone-driven two-wire bus master for the sensor
`timescale 1ns/1ps
module ips_host
  import ips_pkg::*;
#(
  parameter int QTR = HQ_QTR        // clk cycles per quarter scl period
)(
  input  logic        clk,
  input  logic        resetn,
  input  logic        cyc_i,
  input  logic        stb_i,
  input  logic        we_i,
  input  logic [3:0]  adr_i,
  input  logic [31:0] dat_i,
  input  logic [3:0]  sel_i,
  output logic        ack_o,
  output logic [31:0] dat_o,
  ips_if.host         bus
);

  localparam logic [7:0] QTR_LAST = 8'(QTR - 1);

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    ips_kind_t   kind;
    logic        two;
    logic [6:0]  devAddr;
    logic [7:0]  regPtr;
    logic [15:0] tx;
    logic [15:0] rx;
    logic        busy;
    logic        nack;
    logic        done;
    logic        abort;
    logic [2:0]  step;
    logic [1:0]  q;
    logic [7:0]  qCnt;
    logic [3:0]  bitIdx;
    logic [7:0]  sh;
    logic        rxIdx;
    logic        sclOe;
    logic        sdaOe;
    logic [1:0]  sdaS;
  } ips_hst_st_t;

  localparam ips_hst_st_t RST = '{kind: K_WRITE, sdaS: 2'b11, default: '0};

  ips_hst_st_t r;
  ips_hst_st_t n;
  ips_item_t   item;
  logic [7:0]  txByte;
  logic [7:0]  txSh;
  logic        lastRx;
  logic        req;

  ////////////////////////////////////////////////////////////////////////////
  // which bus item a step of a command is
  function automatic ips_item_t itemOf(ips_kind_t k, logic [2:0] s,
                                       logic two, logic ab);
    logic [2:0] base;
    logic [2:0] d;
    base = (k == K_WRITE) ? 3'h3 : (k == K_READ) ? 3'h5 : 3'h2;
    d    = s - base;
    if (ab)
      itemOf = IT_STOP;
    else if (s >= base)
    begin
      if (d > {2'h0, two})
        itemOf = IT_STOP;
      else if (k != K_WRITE)
        itemOf = IT_RX;
      else
        itemOf = (d == 3'h0) ? IT_TX0 : IT_TX1;
    end
    else if (s == 3'h0 || s == 3'h3)
      itemOf = IT_START;
    else if (s == 3'h2)
      itemOf = IT_REG;
    else if (s == 3'h4 || k == K_READNP)
      itemOf = IT_AR;
    else
      itemOf = IT_AW;
  endfunction

  assign item   = itemOf(r.kind, r.step, r.two, r.abort);
  assign txSh   = txByte << r.bitIdx[2:0];
  assign lastRx = (r.rxIdx == r.two);
  assign req    = cyc_i & stb_i & ~r.ack;

  always_comb
  begin
    case (item)
      IT_AW:   txByte = {r.devAddr, 1'b0};
      IT_AR:   txByte = {r.devAddr, 1'b1};
      IT_REG:  txByte = r.regPtr;
      IT_TX0:  txByte = r.tx[7:0];
      IT_TX1:  txByte = r.tx[15:8];
      default: txByte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave and bit engine
  always_comb
  begin
    n      = r;
    n.sdaS = {r.sdaS[0], bus.sda};
    n.ack  = req;
    n.dat  = 32'h0000_0000;
    if (req && we_i)
    begin
      // a command while busy is dropped
      if (adr_i == HB_CMD && !r.busy && sel_i[0])
      begin
        n.kind    = ips_kind_t'(dat_i[CMD_KIND +: 2]);
        n.two     = dat_i[CMD_TWO];
        n.devAddr = dat_i[CMD_DEV +: 7];
        n.regPtr  = dat_i[CMD_REG +: 8];
        n.busy    = 1'b1;
        n.nack    = 1'b0;
        n.done    = 1'b0;
        n.abort   = 1'b0;
        n.step    = 3'h0;
        n.q       = 2'h0;
        n.qCnt    = 8'h00;
        n.bitIdx  = 4'h0;
        n.rxIdx   = 1'b0;
      end
      else if (adr_i == HB_TX)
      begin
        if (sel_i[0])
          n.tx[7:0] = dat_i[7:0];
        if (sel_i[1])
          n.tx[15:8] = dat_i[15:8];
      end
    end
    else if (req)
    begin
      if (adr_i == HB_CMD)
        n.dat = {8'h00, r.regPtr, 1'b0, r.devAddr, 5'h00, r.two, r.kind};
      else if (adr_i == HB_TX)
        n.dat = {16'h0000, r.tx};
      else if (adr_i == HB_RX)
        n.dat = {16'h0000, r.rx};
      else if (adr_i == HB_STAT)
        n.dat = {29'h0, r.done, r.nack, r.busy};
    end

    // actions happen at the first cycle of each scl quarter
    if (r.busy)
    begin
      n.qCnt = (r.qCnt == QTR_LAST) ? 8'h00 : r.qCnt + 8'h01;
      if (r.qCnt == QTR_LAST)
        n.q = r.q + 2'h1;
      if (r.qCnt == 8'h00)
      begin
        case (item)
          IT_START:
          begin
            case (r.q)
              2'h0: n.sdaOe = 1'b0;
              2'h1: n.sclOe = 1'b0;
              2'h2: n.sdaOe = 1'b1;
              default:
              begin
                n.sclOe = 1'b1;
                n.step  = r.step + 3'h1;
              end
            endcase
          end
          IT_STOP:
          begin
            case (r.q)
              2'h0: n.sdaOe = 1'b1;
              2'h1: n.sclOe = 1'b0;
              2'h2: n.sdaOe = 1'b0;
              default:
              begin
                n.busy = 1'b0;
                n.done = 1'b1;
              end
            endcase
          end
          default:
          begin
            case (r.q)
              2'h0:
              begin
                if (r.bitIdx == BIT_ACK)
                  n.sdaOe = (item == IT_RX) && !lastRx;
                else
                  n.sdaOe = (item != IT_RX) && !txSh[7];
              end
              2'h1: n.sclOe = 1'b0;
              2'h2: n.sclOe = 1'b0;
              default:
              begin
                n.sclOe  = 1'b1;
                n.bitIdx = r.bitIdx + 4'h1;
                if (r.bitIdx != BIT_ACK)
                  n.sh = {r.sh[6:0], r.sdaS[1]};
                else
                begin
                  n.bitIdx = 4'h0;
                  n.step   = r.step + 3'h1;
                  if (item == IT_RX)
                  begin
                    if (r.rxIdx)
                      n.rx[15:8] = r.sh;
                    else
                      n.rx[7:0] = r.sh;
                    n.rxIdx = 1'b1;
                  end
                  else if (r.sdaS[1])
                  begin
                    n.nack  = 1'b1;
                    n.abort = 1'b1;   // refused byte: straight to stop
                  end
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      r <= RST;
    else
      r <= n;
  end

  assign ack_o          = r.ack;
  assign dat_o          = r.dat;
  assign bus.hostSclOut = 1'b0;
  assign bus.hostSclOe  = r.sclOe;
  assign bus.hostSdaOut = 1'b0;
  assign bus.hostSdaOe  = r.sdaOe;

endmodule

/* tb/ips_asserts.sv */
// link and power-state checker beside the two-wire carrier
`timescale 1ns/1ps
module ips_asserts
  import ips_pkg::*;
(
  input wire logic     clk,
  input wire logic     resetn,
  input wire logic     scl,
  input wire logic     devSdaOe,
  input wire logic     initDone,
  input wire ips_pwr_t pwrState,
  input wire logic     oscRun,
  input wire logic     alsRun,
  input wire logic     fdRun,
  input wire logic     forcedSleep
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  // properties
  a_no_init_ack: assert property (!initDone |-> !devSdaOe)
    else $error("device drove sda during init");
  a_init_state: assert property (!initDone |-> pwrState == PS_INIT)
    else $error("left init before done");
  a_init_sleep: assert property ($rose(initDone) |->
    pwrState == PS_SLEEP)
    else $error("init did not end in sleep");
  a_sleep_osc: assert property (pwrState == PS_SLEEP [*2] |-> !oscRun)
    else $error("oscillator runs in sleep");
  a_sda_scl_low: assert property ($changed(devSdaOe) |-> !scl)
    else $error("device moved sda while scl high");
  a_als_active: assert property (alsRun |-> pwrState == PS_ACTIVE)
    else $error("light run outside active");
  a_fd_active: assert property (fdRun |-> pwrState == PS_ACTIVE)
    else $error("flicker run outside active");
  a_forced_sleep: assert property (forcedSleep |->
    ##[0:1] pwrState == PS_SLEEP)
    else $error("forced flag without sleep");
endmodule

/* tb/test_i2c_port_and_power_states.sv */
// bench: wishbone-driven host against the sensor port
`timescale 1ns/1ps
module test_i2c_port_and_power_states
  import ips_pkg::*;
;
  logic        clk, resetn, cyc, stb, we, ack, intEvent;
  logic        initDone, oscRun, alsRun, fdRun, forcedSleep;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, q, stat;
  logic [15:0] alsData, agcSamples;
  ips_pwr_t    pwrState;
  int          err_total = 0, checks = 0;
  ips_if link ();
  ips_host #(.QTR(4)) ips_host_i (.clk, .resetn, .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(4'hF), .ack_o(ack),
    .dat_o(rdat), .bus(link));
  ips_device #(.INIT_CYCLES(400)) ips_device_i (.clk, .resetn, .bus(link),
    .alsData, .intEvent, .pwrState, .initDone, .oscRun, .alsRun, .fdRun,
    .forcedSleep, .agcSamples);
  ips_asserts ips_asserts_i (.clk, .resetn, .scl(link.scl),
    .devSdaOe(link.devSdaOe), .initDone, .pwrState, .oscRun, .alsRun,
    .fdRun, .forcedSleep);
  ////////////////////////////////////////////////////////////////////////
  // clock, 100 ns period
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task give_verdict;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  // classic single cycle, held until ack is seen
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin err_total++; give_verdict; end
    r = rdat;
    cyc <= 0; stb <= 0;
    @(posedge clk);
  endtask
  // one serial transfer: data, command, poll busy, fetch rx
  task automatic xfer(input ips_kind_t k, input logic two,
                      input logic [7:0] r, input logic [15:0] d);
    int n;
    n = 0;
    wb(1, HB_TX, {16'h0000, d}, stat);
    wb(1, HB_CMD, {8'h00, r, 1'b0, 7'h29, 5'h00, two, k}, stat);
    do begin wb(0, HB_STAT, 0, stat); n++; end
      while (stat[0] !== 1'b0 && n < 900);
    if (stat[0] !== 1'b0) begin err_total++; give_verdict; end
    wb(0, HB_RX, 0, q);
  endtask
  task automatic wait_pwr(input ips_pwr_t e);
    int n;
    n = 0;
    while (pwrState !== e && n < 1000) begin @(posedge clk); n++; end
    chk("pwrState", e, pwrState);
    if (pwrState !== e) give_verdict;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    resetn = 0; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0;
    intEvent = 0; alsData = 16'hBEEF;
    repeat (2) @(posedge clk);
    resetn <= 1;
    xfer(K_READ, 0, REG_ID, 0);
    chk("init nack", 1, stat[1]);
    chk("init state", PS_INIT, pwrState);
    wait_pwr(PS_SLEEP);
    xfer(K_READ, 0, REG_ID, 0);
    chk("id", 8'hA5, q[7:0]);
    chk("asleep", PS_SLEEP, pwrState);
    xfer(K_WRITE, 1, REG_AGC_LO, 16'h1234);
    chk("agc", 16'h1234, agcSamples);
    xfer(K_READ, 0, REG_ALS_LO, 0);
    chk("als lo", 8'hEF, q[7:0]);
    alsData <= 16'h0000;
    xfer(K_READNP, 0, 0, 0);
    chk("als hi", 8'hBE, q[7:0]);
    alsData <= 16'h5AC3;
    xfer(K_READ, 1, REG_ALS_LO, 0);
    chk("als pair", 32'h0000_5AC3, q);
    xfer(K_WRITE, 0, REG_ENABLE, 16'h0001);
    wait_pwr(PS_IDLE);
    xfer(K_WRITE, 0, REG_ENABLE, 16'h0043);
    wait_pwr(PS_ACTIVE);
    chk("runs", 2'b11, {alsRun, fdRun});
    xfer(K_WRITE, 0, REG_ENABLE, 16'h0001);
    wait_pwr(PS_IDLE);
    xfer(K_WRITE, 0, REG_CFG0, 16'h0048);
    xfer(K_WRITE, 0, REG_ENABLE, 16'h0003);
    wait_pwr(PS_ACTIVE);
    intEvent <= 1;
    @(posedge clk);
    intEvent <= 0;
    wait_pwr(PS_SLEEP);
    xfer(K_READ, 0, REG_ENABLE, 0);
    chk("enable kept", 8'h03, q[7:0]);
    xfer(K_READ, 0, REG_STATUS4, 0);
    chk("flag", 1, q[0]);
    xfer(K_WRITE, 0, REG_CONTROL, 16'h0008);
    wait_pwr(PS_ACTIVE);
    chk("flag clear", 0, forcedSleep);
    give_verdict;
  end
endmodule
